//--- src/cmb_pkg.sv
// Constants and types for the core memory bank control block
package cmb_pkg;
    localparam int WORD_W = 16;
    localparam int BYTE_W = 8;
    localparam int BANK_WORDS = 8192;
    localparam int WADDR_W = 13;
    localparam int BUS_ADDR_W = 18;
    localparam int ROW_N = 128;
    localparam int COL_N = 64;
    localparam int ROW_W = 7;
    localparam int COL_W = 6;
    localparam int CLK_PERIOD_NS = 4;
    localparam int ACCESS_NS = 400;
    localparam int CYCLE_NS = 900;
    // Longest times round down to whole cycles
    localparam int ACCESS_CYC = ACCESS_NS / CLK_PERIOD_NS;
    localparam int CYCLE_CYC = CYCLE_NS / CLK_PERIOD_NS;
    localparam int CNT_W = 8;
    // Bus cycle codes on the two control lines
    localparam logic [1:0] CYC_DATI = 2'h0;
    localparam logic [1:0] CYC_DATIP = 2'h1;
    localparam logic [1:0] CYC_DATO = 2'h2;
    localparam logic [1:0] CYC_DATOB = 2'h3;
    localparam logic [BUS_ADDR_W-1:0] BASE_RESET = 18'h00000;

    typedef enum logic [2:0] {
        CMB_IDLE = 3'b000,
        CMB_READ = 3'b001,
        CMB_WAIT_MSYN = 3'b010,
        CMB_RESTORE = 3'b011,
        CMB_PAUSE = 3'b100,
        CMB_WRITE = 3'b101
    } cmb_state_t;
endpackage

//--- src/cmb_bank.sv
// Core memory bank control: bus slave, read-restore and write sequencing
`timescale 1ns/100ps
module cmb_bank
    import cmb_pkg::*;
#(
    parameter logic [BUS_ADDR_W-1:0] BASE = BASE_RESET
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Strapping
    input wire logic interleave_en,
    input wire logic bank_odd,
    // Bus master request
    input wire logic msyn,
    input wire logic [1:0] cyc,
    input wire logic [BUS_ADDR_W-1:0] addr,
    input wire logic [WORD_W-1:0] data_in,
    // Slave answer
    output logic ssyn,
    output logic [WORD_W-1:0] data_out,
    output logic data_oe,
    output logic busy
);
    // One array per bit plane, row by column
    logic [ROW_N*COL_N-1:0] plane [WORD_W];
    cmb_state_t state;
    logic [WORD_W-1:0] hold;
    logic [CNT_W-1:0] cnt;
    logic [ROW_W-1:0] row;
    logic [COL_W-1:0] col;
    logic [1:0] cur_cyc;
    logic hi_byte;
    logic write_phase;

    // Bank select; interleave moves the bank choice into word address bit 0
    function automatic logic hit(input logic [BUS_ADDR_W-1:0] a, input logic il,
                                 input logic odd);
        if (il)
            hit = (a[BUS_ADDR_W-1:WADDR_W+2] == BASE[BUS_ADDR_W-1:WADDR_W+2])
                  && (a[1] == odd);
        else
            hit = (a[BUS_ADDR_W-1:WADDR_W+1] == BASE[BUS_ADDR_W-1:WADDR_W+1]);
    endfunction

    function automatic logic [WADDR_W-1:0] word_ix(input logic [BUS_ADDR_W-1:0] a,
                                                  input logic il);
        word_ix = il ? a[WADDR_W+1:2] : a[WADDR_W:1];
    endfunction

    logic [WADDR_W-1:0] wix;
    assign wix = word_ix(addr, interleave_en);
    wire logic req = msyn && hit(addr, interleave_en, bank_odd);

    // Write data merge for a byte write keeps the unaddressed byte
    logic [WORD_W-1:0] next_hold;
    always_comb begin
        next_hold = data_in;
        if (cyc == CYC_DATOB) begin
            if (addr[0])
                next_hold = {data_in[WORD_W-1:BYTE_W], hold[BYTE_W-1:0]};
            else
                next_hold = {hold[WORD_W-1:BYTE_W], data_in[BYTE_W-1:0]};
        end
    end

    // Cycle sequencer
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state <= CMB_IDLE;
            cnt <= '0;
            row <= '0;
            col <= '0;
            cur_cyc <= CYC_DATI;
            hi_byte <= 1'b0;
            write_phase <= 1'b0;
        end else begin
            unique case (state)
                CMB_IDLE: begin
                    if (req) begin
                        {row, col} <= wix;
                        cur_cyc <= cyc;
                        hi_byte <= addr[0];
                        cnt <= '0;
                        state <= CMB_READ; // Every cycle starts with a destructive read
                    end
                end
                CMB_READ: begin
                    cnt <= cnt + 1'b1;
                    if (cnt == CNT_W'(ACCESS_CYC - 2)) begin
                        if (cur_cyc == CYC_DATIP)
                            state <= CMB_PAUSE;
                        else if (cur_cyc == CYC_DATI)
                            state <= CMB_WAIT_MSYN;
                        else
                            state <= CMB_WRITE;
                    end
                end
                CMB_WAIT_MSYN: begin
                    cnt <= cnt + 1'b1;
                    state <= CMB_RESTORE;
                end
                CMB_RESTORE: begin
                    cnt <= cnt + 1'b1;
                    if (cnt >= CNT_W'(CYCLE_CYC - 2) && !msyn)
                        state <= CMB_IDLE;
                end
                CMB_PAUSE: begin
                    // Location stays cleared until the master writes it
                    if (!msyn)
                        cnt <= '0;
                    if (msyn && (cyc == CYC_DATO || cyc == CYC_DATOB)
                        && hit(addr, interleave_en, bank_odd)) begin
                        cur_cyc <= cyc;
                        hi_byte <= addr[0];
                        cnt <= CNT_W'(ACCESS_CYC - 1);
                        state <= CMB_WRITE;
                    end
                end
                CMB_WRITE: begin
                    cnt <= cnt + 1'b1;
                    if (cnt >= CNT_W'(CYCLE_CYC - 2) && !msyn)
                        state <= CMB_IDLE;
                end
                default: state <= CMB_IDLE;
            endcase
            write_phase <= (state == CMB_WAIT_MSYN) || (state == CMB_WRITE && cnt ==
                CNT_W'(ACCESS_CYC - 1));
        end
    end

    // Holding register: captures the read word, then bus data for writes
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            hold <= '0;
        end else if (state == CMB_IDLE && req) begin
            for (int b = 0; b < WORD_W; b++)
                hold[b] <= plane[b][wix];
        end else if ((state == CMB_READ && cnt == CNT_W'(ACCESS_CYC - 2)
                      && (cur_cyc == CYC_DATO || cur_cyc == CYC_DATOB))
                     || (state == CMB_PAUSE && msyn && hit(addr, interleave_en, bank_odd)
                      && (cyc == CYC_DATO || cyc == CYC_DATOB))) begin
            hold <= next_hold;
        end
    end

    // Core planes: clear on read, rewrite from the holding register
    generate
        for (genvar b = 0; b < WORD_W; b++) begin : g_plane
            always_ff @(posedge clk_sys) begin
                if (state == CMB_IDLE && req)
                    plane[b][wix] <= 1'b0;
                else if (write_phase)
                    plane[b][{row, col}] <= hold[b];
            end
        end
    endgenerate

    // Slave answer
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            ssyn <= 1'b0;
            data_out <= '0;
            data_oe <= 1'b0;
            busy <= 1'b0;
        end else begin
            busy <= (state != CMB_IDLE);
            if (state == CMB_READ && cnt == CNT_W'(ACCESS_CYC - 2)) begin
                ssyn <= 1'b1;
                if (cur_cyc == CYC_DATI || cur_cyc == CYC_DATIP) begin
                    data_out <= hold;
                    data_oe <= 1'b1;
                end
            end else if (!msyn) begin
                ssyn <= 1'b0;
                data_oe <= 1'b0;
            end else if (state == CMB_PAUSE && msyn && (cyc == CYC_DATO || cyc == CYC_DATOB)
                         && hit(addr, interleave_en, bank_odd)) begin
                ssyn <= 1'b1;
            end
        end
    end

    // Checks
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    read_access_a: assert property ($rose(busy) |-> ##[1:99] ssyn)
        else $error("Read answer later than access time");
    no_answer_unsel_a: assert property (state == CMB_IDLE && !req |=> state == CMB_IDLE
        && !ssyn && !busy)
        else $error("Bank started without being addressed");
    dati_restore_a: assert property (state == CMB_WAIT_MSYN |=> state == CMB_RESTORE
        && write_phase)
        else $error("DATI restore not written");
    datip_hold_a: assert property (state == CMB_PAUSE && !msyn |=> state == CMB_PAUSE)
        else $error("Paused location released without a write");
    write_data_a: assert property (state == CMB_WRITE && write_phase |->
        hold == $past(hold))
        else $error("Holding register changed during write");
    data_drive_a: assert property (data_oe |-> ssyn)
        else $error("Data driven without acknowledge");
    idle_noout_a: assert property (state == CMB_IDLE && !msyn |=> !data_oe)
        else $error("Data left on bus");
    byte_keep_a: assert property (state == CMB_READ && cur_cyc == CYC_DATOB
        && cnt == CNT_W'(ACCESS_CYC - 2) && !hi_byte && addr[0] == 1'b0
        |=> hold[WORD_W-1:BYTE_W] == $past(hold[WORD_W-1:BYTE_W]))
        else $error("Byte write disturbed other byte");
    cov_dati_c: cover property (state == CMB_RESTORE ##1 state == CMB_IDLE);
    cov_datip_c: cover property (state == CMB_PAUSE ##[1:50] state == CMB_WRITE);
    cov_datob_c: cover property (state == CMB_WRITE && cur_cyc == CYC_DATOB);
endmodule // cmb_bank

//--- dv/cmb_master.sv
// Bus master model that requests cycles from the memory bank
`timescale 1ns/100ps
module cmb_master
    import cmb_pkg::*;
(
    // Clock and slave answer
    input wire logic clk_sys,
    input wire logic ssyn,
    input wire logic busy,
    // Master request
    output logic msyn = 1'b0,
    output logic [1:0] cyc = 2'h0,
    output logic [BUS_ADDR_W-1:0] addr = 18'h00000,
    output logic [WORD_W-1:0] data_in = 16'h0000
);
    // Holds the request until ssyn is sampled and hold more cycles, then drives the lines to their inverse
    task automatic xfer(input logic [1:0] c, input logic [BUS_ADDR_W-1:0] a,
        input logic [WORD_W-1:0] d, input int hold, output logic ok,
        output int lat, output int tot);
        int n;
        ok = 1'b0;
        lat = 0;
        @(posedge clk_sys);
        msyn <= 1'b1;
        cyc <= c;
        addr <= (c == CYC_DATOB) ? a : {a[BUS_ADDR_W-1:1], 1'b0};
        data_in <= d;
        // A missing answer ends in a bus timeout instead of a hang
        for (n = 0; n < 150 && !ok; n++) begin
            @(posedge clk_sys);
            ok = (ssyn === 1'b1);
            lat = n;
        end
        repeat (hold) @(posedge clk_sys);
        msyn <= 1'b0;
        cyc <= ~c;
        // Released lines show the inverse, so stale data cannot pass by luck
        addr <= ~a;
        data_in <= ~d;
        tot = lat + hold;
        // A paused bank stays busy until its write arrives, so only the answer is awaited
        while ((ssyn !== 1'b0 || (busy !== 1'b0 && c != CYC_DATIP)) && tot < 400) begin
            @(posedge clk_sys);
            tot++;
        end
    endtask
endmodule // cmb_master

//--- dv/cmb_bank_tb.sv
// Self-checking testbench for the core memory bank control block
`timescale 1ns/100ps
module cmb_bank_tb;
    import cmb_pkg::*;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic interleave_en = 1'b0;
    logic bank_odd = 1'b0;
    logic msyn, ssyn, data_oe, busy, ok;
    logic ssyn_q = 1'b0;
    logic [1:0] cyc;
    logic [BUS_ADDR_W-1:0] addr;
    logic [WORD_W-1:0] data_in, data_out;
    logic [WORD_W-1:0] exp_q[$];
    logic [WORD_W-1:0] mem [logic [BUS_ADDR_W-1:0]];
    int errors = 0;
    int checks_done = 0;
    int seed = 31517;
    int lat, tot;

    initial begin
        forever #2 clk_sys = ~clk_sys;
    end

    cmb_bank cmb_bank_i (.clk_sys(clk_sys), .rst_n(rst_n), .interleave_en(interleave_en),
        .bank_odd(bank_odd), .msyn(msyn), .cyc(cyc), .addr(addr), .data_in(data_in),
        .ssyn(ssyn), .data_out(data_out), .data_oe(data_oe), .busy(busy));
    cmb_master cmb_master_i (.clk_sys(clk_sys), .ssyn(ssyn), .busy(busy), .msyn(msyn),
        .cyc(cyc), .addr(addr), .data_in(data_in));

    task automatic check(input string what, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            errors++;
            $display("Error %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic summarize();
        if (errors == 0 && checks_done > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // One bus cycle; the reference memory is updated before the request goes out
    task automatic op(input logic [1:0] c, input logic [BUS_ADDR_W-1:0] a, input int hold,
        input logic hit);
        logic [WORD_W-1:0] d;
        logic [BUS_ADDR_W-1:0] k;
        d = WORD_W'($random(seed));
        k = {a[BUS_ADDR_W-1:1], 1'b0};
        // Byte data rides on both lanes so either lane choice is served
        if (c == CYC_DATOB) d = {d[7:0], d[7:0]};
        if (hit && !c[1]) exp_q.push_back(mem[k]);
        if (hit && c == CYC_DATO) mem[k] = d;
        if (hit && c == CYC_DATOB && a[0]) mem[k][15:8] = d[7:0];
        if (hit && c == CYC_DATOB && !a[0]) mem[k][7:0] = d[7:0];
        cmb_master_i.xfer(c, a, d, hold, ok, lat, tot);
        check("ssyn", {31'h0, hit}, {31'h0, ok});
        if (ok) check("access", 1, lat <= ACCESS_CYC + 1);
        if (ok && hold == 0 && c != CYC_DATIP) check("cycle", 1, tot <= CYCLE_CYC + 3);
    endtask

    // Result watcher: each new answer with data_oe set consumes the oldest expected word
    always @(posedge clk_sys) begin
        ssyn_q <= ssyn;
        if (ssyn === 1'b1 && ssyn_q !== 1'b1) begin
            check("data_oe", {31'h0, ~cyc[1]}, {31'h0, data_oe});
            if (data_oe === 1'b1) check("data_out", exp_q.pop_front(), data_out);
        end
    end

    initial begin
        repeat (20000) @(posedge clk_sys);
        errors++;
        summarize();
    end

    initial begin
        logic [BUS_ADDR_W-1:0] tbl [4];
        tbl = '{18'h00000, 18'h00002, 18'h03ffe, 18'h00000};
        tbl[3] = BUS_ADDR_W'($random(seed)) & 18'h03ffc;
        repeat (16) @(posedge clk_sys);
        rst_n <= 1'b1;
        foreach (tbl[i]) begin
            op(CYC_DATO, tbl[i], 0, 1'b1);
            op(CYC_DATI, tbl[i], 0, 1'b1);
            op(CYC_DATI, tbl[i], 3, 1'b1);
        end
        op(CYC_DATOB, 18'h00003, 0, 1'b1);
        op(CYC_DATOB, 18'h00002, 0, 1'b1);
        op(CYC_DATI, 18'h00002, 0, 1'b1);
        op(CYC_DATIP, 18'h00000, 0, 1'b1);
        op(CYC_DATO, 18'h00000, 0, 1'b1);
        op(CYC_DATIP, 18'h03ffe, 2, 1'b1);
        op(CYC_DATOB, 18'h03fff, 0, 1'b1);
        op(CYC_DATI, 18'h00000, 0, 1'b1);
        op(CYC_DATI, 18'h03ffe, 0, 1'b1);
        op(CYC_DATI, 18'h04000, 0, 1'b0);
        op(CYC_DATO, 18'h3fffe, 0, 1'b0);
        interleave_en <= 1'b1;
        op(CYC_DATO, 18'h04004, 0, 1'b1);
        op(CYC_DATI, 18'h04004, 0, 1'b1);
        op(CYC_DATI, 18'h00006, 0, 1'b0);
        bank_odd <= 1'b1;
        op(CYC_DATO, 18'h00006, 0, 1'b1);
        op(CYC_DATI, 18'h00006, 0, 1'b1);
        op(CYC_DATI, 18'h00004, 0, 1'b0);
        check("pending", 0, exp_q.size());
        summarize();
    end
endmodule // cmb_bank_tb
